// ---- hw/break_deadtime_defines.vh ----
// Purpose: constants for the break, dead-time and burst-window slice
// Assumes: 32-bit APB, byte addresses, one 16-bit register per word
// Notes: masks other than M_DCR and M_LOCK mark bits that a lock level protects from writes
// Behaviour
// - enabled break clears master enable asynchronously
// - master enable gates channel and complementary outputs
// - auto re-arm sets master enable on update
// - break polarity bit selects pin active level
// - break gate enables pin and clock-fail sources
// - polarity and gate writes act one cycle later
// - run off-state bit: drive inactive or disable
// - idle off-state bit: force idle or disable
// - lock 00 open; 01 blocks dead-time, idle, break
// - lock 10 adds polarity and off-state bits
// - lock 11 adds compare mode and preload
// - lock field accepted once after reset
// - dead-time length from four-tier field encoding
// - burst length field plus one transfers
// - any burst window access is a burst transfer
// - burst base index counts from first register
// - window access hits base plus index register
`ifndef BREAK_DEADTIME_DEFINES_VH
`define BREAK_DEADTIME_DEFINES_VH
`define OFF_BDTR 8'h44
`define OFF_DCR 8'h48
`define OFF_DMAR 8'h4c
`define IDX_CR2 5'h01
`define IDX_CCMR1 5'h06
`define IDX_CCER 5'h08
`define IDX_LAST_EXT 5'h10
`define IDX_BDTR 5'h11
`define IDX_DCR 5'h12
`define RST16 16'h0000
`define B_MOE 15
`define B_AOE 14
`define B_BKP 13
`define B_BKE 12
`define B_RUN_OFF_STATE_SEL 11
`define B_IDLE_OFF_STATE_SEL 10
`define F_LOCK 9:8
`define F_DTG 7:0
`define F_BLEN 12:8
`define F_BASE 4:0
`define M_DCR 16'h1f1f
`define M_LOCK 15'h0300
`define M_L1_BDTR 16'h70ff
`define M_L2_BDTR 16'h0c00
`define M_CR2_OIS 16'h7f00
`define M_CCER_POL 4'ha
`define M_CCMR_L3 8'h78
`define LK_OFF 2'b00
`define LK_3 2'b11
`define CCS_OUT 2'b00
`define DT_BASE2 11'h040
`define DT_BASE3 11'h020
`endif

// ---- hw/break_deadtime_dma_burst.v ----
// Purpose: master output enable with break, off-state selection, write lock,
//   dead-time insertion and the burst window onto the timer register run
// Assumes: oc_ref and update_event come from the timer core on pclk
// Notes: the remaining timer registers are held here as plain storage so
//   that the burst window and the lock scheme have real targets
`include "break_deadtime_defines.vh"
`default_nettype none
module break_deadtime_dma_burst #(
	parameter NCH = 3,
	parameter [7:0] DTS_DIV = 8'h01
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire break_pin,
	input wire clock_fail_detect,
	input wire update_event,
	input wire [NCH-1:0] oc_ref,
	output reg [NCH-1:0] oc_out,
	output reg [NCH-1:0] oc_oe,
	output reg [NCH-1:0] ocn_out,
	output reg [NCH-1:0] ocn_oe,
	output reg outputs_master_enable
);

reg [15:0] treg [0:`IDX_LAST_EXT];
reg [14:0] bdtr_q;
reg [1:0] lock_q;
reg lock_done_q;
reg moe_q;
reg [15:0] dcr_q;
reg [4:0] bidx_q;
reg bke_eff_q;
reg bkp_eff_q;
reg brk_m_q;
reg brk_s_q;
reg cfd_m_q;
reg cfd_s_q;
reg [7:0] dts_cnt_q;
reg dts_tick_q;
reg [15:0] pmask;
integer i;

// burst window target: base plus running index, overflow is unmapped
wire is_dmar = paddr == `OFF_DMAR;
wire [5:0] win_sum = {1'b0, dcr_q[`F_BASE]} + {1'b0, bidx_q};
wire [4:0] aidx = is_dmar ? win_sum[4:0] : paddr[6:2];
wire aligned = paddr[1:0] == 2'b00;
wire hit = aligned & ~paddr[7] & ~(is_dmar & win_sum[5]) & (aidx <= `IDX_DCR);
wire acc_setup = psel & ~penable;
wire acc_done = psel & penable & pready;
wire wr_hit = acc_done & pwrite & hit;

function [15:0] rd_word(input [4:0] idx);
	begin
		if (idx == `IDX_BDTR) begin
			rd_word = {moe_q, bdtr_q[14:10], lock_q, bdtr_q[`F_DTG]};
		end else if (idx == `IDX_DCR) begin
			rd_word = dcr_q;
		end else if (idx <= `IDX_LAST_EXT) begin
			rd_word = treg[idx];
		end else begin
			rd_word = `RST16;
		end
	end
endfunction

// channel direction lives in the compare mode registers, two per word
function ch_out(input integer c);
	begin
		ch_out = treg[`IDX_CCMR1 + c / 2][8 * (c % 2) +: 2] == `CCS_OUT;
	end
endfunction

function [10:0] dt_ticks(input [7:0] g);
	begin
		if (!g[7]) begin
			dt_ticks = {3'b000, g};
		end else if (!g[6]) begin
			dt_ticks = (`DT_BASE2 + {5'b00000, g[5:0]}) << 1;
		end else if (!g[5]) begin
			dt_ticks = (`DT_BASE3 + {6'b000000, g[4:0]}) << 3;
		end else begin
			dt_ticks = (`DT_BASE3 + {6'b000000, g[4:0]}) << 4;
		end
	end
endfunction

// bits that the current lock level keeps from being written
always @* begin
	pmask = `RST16;
	if (aidx == `IDX_BDTR) begin
		if (lock_q != `LK_OFF) begin
			pmask = `M_L1_BDTR;
		end
		if (lock_q[1]) begin
			pmask = pmask | `M_L2_BDTR;
		end
	end else if (aidx == `IDX_CR2) begin
		if (lock_q != `LK_OFF) begin
			pmask = `M_CR2_OIS;
		end
	end else if (aidx == `IDX_CCER) begin
		for (i = 0; i < 4; i = i + 1) begin
			if (lock_q[1] && ch_out(i)) begin
				pmask[4 * i +: 4] = `M_CCER_POL;
			end
		end
	end else if (aidx == `IDX_CCMR1 || aidx == `IDX_CCMR1 + 5'h01) begin
		for (i = 0; i < 2; i = i + 1) begin
			if (lock_q == `LK_3 && treg[aidx][8 * i +: 2] == `CCS_OUT) begin
				pmask[8 * i +: 8] = `M_CCMR_L3;
			end
		end
	end
end

// apb slave: answer is registered in the setup cycle, so no wait states
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		prdata <= 32'h0000_0000;
		pslverr <= 1'b0;
	end else begin
		pready <= acc_setup;
		if (acc_setup) begin
			prdata <= {16'h0000, hit ? rd_word(aidx) : `RST16};
			pslverr <= ~hit;
		end
	end
end

// burst index moves on every completed window access, even refused ones
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		bidx_q <= 5'h00;
	end else if (wr_hit && aidx == `IDX_DCR) begin
		bidx_q <= 5'h00;
	end else if (acc_done && is_dmar) begin
		if (bidx_q >= dcr_q[`F_BLEN]) begin
			bidx_q <= 5'h00;
		end else begin
			bidx_q <= bidx_q + 5'h01;
		end
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		dcr_q <= `RST16;
	end else if (wr_hit && aidx == `IDX_DCR) begin
		dcr_q <= pwdata[15:0] & `M_DCR;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		for (i = 0; i <= `IDX_LAST_EXT; i = i + 1) begin
			treg[i] <= `RST16;
		end
	end else if (wr_hit && aidx <= `IDX_LAST_EXT) begin
		treg[aidx] <= (treg[aidx] & pmask) | (pwdata[15:0] & ~pmask);
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		bdtr_q <= 15'h0000;
		lock_q <= `LK_OFF;
		lock_done_q <= 1'b0;
	end else if (wr_hit && aidx == `IDX_BDTR) begin
		bdtr_q <= ((bdtr_q & pmask[14:0]) | (pwdata[14:0] & ~pmask[14:0])) & ~`M_LOCK;
		lock_done_q <= 1'b1;
		if (!lock_done_q) begin
			lock_q <= pwdata[`F_LOCK];
		end
	end
end

// break settings reach the protection path one cycle after the write
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		bke_eff_q <= 1'b0;
		bkp_eff_q <= 1'b0;
	end else begin
		bke_eff_q <= bdtr_q[`B_BKE];
		bkp_eff_q <= bdtr_q[`B_BKP];
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		brk_m_q <= 1'b0;
		brk_s_q <= 1'b0;
		cfd_m_q <= 1'b0;
		cfd_s_q <= 1'b0;
	end else begin
		brk_m_q <= break_pin;
		brk_s_q <= brk_m_q;
		cfd_m_q <= clock_fail_detect;
		cfd_s_q <= cfd_m_q;
	end
end

// the raw path clears the enable without a clock; the synced copy only
// blocks the automatic re-arm, so a glitch can never set the enable
wire brk_async = bke_eff_q & ((break_pin == bkp_eff_q) | clock_fail_detect);
wire brk_sync = bke_eff_q & ((brk_s_q == bkp_eff_q) | cfd_s_q);

always @(posedge pclk or negedge presetn or posedge brk_async) begin
	if (!presetn) begin
		moe_q <= 1'b0;
	end else if (brk_async) begin
		moe_q <= 1'b0;
	end else if (wr_hit && aidx == `IDX_BDTR) begin
		moe_q <= pwdata[`B_MOE];
	end else if (update_event && bdtr_q[`B_AOE] && !brk_sync) begin
		moe_q <= 1'b1;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		outputs_master_enable <= 1'b0;
	end else begin
		outputs_master_enable <= moe_q;
	end
end

// dead-time clock enable from pclk
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		dts_cnt_q <= 8'h00;
		dts_tick_q <= 1'b0;
	end else if (dts_cnt_q >= DTS_DIV - 8'h01) begin
		dts_cnt_q <= 8'h00;
		dts_tick_q <= 1'b1;
	end else begin
		dts_cnt_q <= dts_cnt_q + 8'h01;
		dts_tick_q <= 1'b0;
	end
end

wire [10:0] dt_len = dt_ticks(bdtr_q[`F_DTG]);
wire run_off_state_sel = bdtr_q[`B_RUN_OFF_STATE_SEL];
wire idle_off_state_sel = bdtr_q[`B_IDLE_OFF_STATE_SEL];

genvar c;
generate
	for (c = 0; c < NCH; c = c + 1) begin : chan
		reg [10:0] dtc_q;
		reg ref_q;
		wire cce = treg[`IDX_CCER][4 * c];
		wire ccp = treg[`IDX_CCER][4 * c + 1];
		wire ccne = treg[`IDX_CCER][4 * c + 2];
		wire ccnp = treg[`IDX_CCER][4 * c + 3];
		wire ois = treg[`IDX_CR2][8 + 2 * c];
		wire oisn = treg[`IDX_CR2][9 + 2 * c];
		wire is_out = treg[`IDX_CCMR1 + c / 2][8 * (c % 2) +: 2] == `CCS_OUT;
		wire dt_done = dtc_q == 11'h000;
		wire main_act = (cce & ccne) ? (ref_q & dt_done) : ref_q;
		wire comp_act = (cce & ccne) ? (~ref_q & dt_done) : ~ref_q;

		// each reference edge restarts the gap before the other side rises
		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ref_q <= 1'b0;
				dtc_q <= 11'h000;
			end else begin
				ref_q <= oc_ref[c];
				if (oc_ref[c] != ref_q) begin
					dtc_q <= dt_len;
				end else if (dts_tick_q && !dt_done) begin
					dtc_q <= dtc_q - 11'h001;
				end
			end
		end

		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				oc_out[c] <= 1'b0;
				oc_oe[c] <= 1'b0;
				ocn_out[c] <= 1'b0;
				ocn_oe[c] <= 1'b0;
			end else if (!is_out) begin
				oc_out[c] <= 1'b0;
				oc_oe[c] <= 1'b0;
				ocn_out[c] <= 1'b0;
				ocn_oe[c] <= 1'b0;
			end else if (moe_q) begin
				oc_oe[c] <= cce | (run_off_state_sel & ccne);
				oc_out[c] <= cce ? (main_act ^ ccp) : ccp;
				ocn_oe[c] <= ccne | (run_off_state_sel & cce);
				ocn_out[c] <= ccne ? (comp_act ^ ccnp) : ccnp;
			end else begin
				oc_oe[c] <= idle_off_state_sel & (cce | ccne);
				oc_out[c] <= ois;
				ocn_oe[c] <= idle_off_state_sel & (cce | ccne);
				ocn_out[c] <= oisn;
			end
		end
	end
endgenerate

endmodule
`default_nettype wire

// ---- verif/break_deadtime_dma_burst_asserts.sv ----
// Purpose: bus answer and re-arm checks at the top ports
// Assumes: zero-wait slave, status bit copied one cycle late
// Notes: break effects hinge on hidden gate state, so the bench judges them
`default_nettype none
module break_deadtime_dma_burst_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic update_event,
	input wire logic outputs_master_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire setup = psel && !penable;
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	AST_ACCESS_ANSWER: assert property (setup |=> s_answer)
		else $error("bus answer missing");
	AST_READY_CAUSE: assert property (pready |-> $past(setup))
		else $error("answer without setup");
	AST_UNMAPPED: assert property (setup && paddr >= 8'h50 |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped not refused");
	AST_UNALIGNED: assert property (setup && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("unaligned not refused");
	AST_MAPPED_OK: assert property (setup && paddr <= 8'h48 && paddr[1:0] == 2'b00 |=> !pslverr)
		else $error("mapped access refused");
	AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read half set");
	AST_DATA_HOLD: assert property (!pready |-> $stable(prdata) && $stable(pslverr))
		else $error("read data moved");
	AST_REARM_CAUSE: assert property ($rose(outputs_master_enable)
		|-> $past(update_event || (psel && penable && pwrite), 2))
		else $error("master enable rose uncaused");
endmodule
bind break_deadtime_dma_burst break_deadtime_dma_burst_asserts chk_i (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .update_event(update_event),
	.outputs_master_enable(outputs_master_enable));
`default_nettype wire

// ---- verif/break_deadtime_dma_burst_tb_top.sv ----
// Purpose: directed register tests of break, lock and burst window
// Assumes: zero-wait bus answer, default dead-time divider
// Notes: oc_ref rises once on channel 0 only, so just that rising dead-time gap is tested
`default_nettype none
module break_deadtime_dma_burst_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, update_event = 0;
	logic trip_pin = 0, trip_cf = 0, break_pin, clock_fail_detect, pready, pslverr, ome, rerr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic [2:0] oc_oe, oc_out, ocn_out;
	logic [2:0] oc_ref = 3'h0;
	int bad_count = 0, check_count = 0;
	initial forever #20 pclk = ~pclk;
	break_source src (.pclk(pclk), .pol(1'b0), .trip_pin(trip_pin), .trip_cf(trip_cf),
		.break_pin(break_pin), .clock_fail_detect(clock_fail_detect));
	break_deadtime_dma_burst uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .break_pin(break_pin), .clock_fail_detect(clock_fail_detect),
		.update_event(update_event), .oc_ref(oc_ref), .oc_out(oc_out), .oc_oe(oc_oe),
		.ocn_out(ocn_out),
		.ocn_oe(), .outputs_master_enable(ome));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
		int n;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= {16'h0000, d};
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		// a missing answer counts against the run
		if (pready !== 1'b1) begin
			bad_count++;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		xfer(a, 1'b0, 16'h0000);
		chk(rdat, {16'h0000, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h44, 16'h0000);
		rd(8'h48, 16'h0000);
		xfer(8'h08, 1'b1, 16'h0001);
		xfer(8'h20, 1'b1, 16'h0001);
		xfer(8'h44, 1'b1, 16'h5155);
		xfer(8'h44, 1'b1, 16'habaa);
		rd(8'h44, 16'hd955);
		xfer(8'h04, 1'b1, 16'h7f01);
		rd(8'h04, 16'h0001);
		tick(2);
		chk(oc_oe, 3'h1);
		$display("lock test done");
		trip_pin <= 1'b1;
		tick(3);
		chk(ome, 1'b0);
		chk(oc_oe, 3'h0);
		rd(8'h44, 16'h5955);
		trip_pin <= 1'b0;
		tick(5);
		chk(ome, 1'b0);
		update_event <= 1'b1;
		tick(1);
		update_event <= 1'b0;
		tick(3);
		chk(ome, 1'b1);
		trip_cf <= 1'b1;
		tick(3);
		chk(ome, 1'b0);
		trip_cf <= 1'b0;
		$display("break test done");
		xfer(8'h48, 1'b1, 16'h020e);
		rd(8'h48, 16'h020e);
		for (int i = 0; i < 4; i++) xfer(8'h4c, 1'b1, 16'h1000 + 16'(i));
		rd(8'h38, 16'h1003);
		rd(8'h3c, 16'h1001);
		rd(8'h40, 16'h1002);
		rd(8'h50, 16'h0000);
		chk(rerr, 1'b1);
		$display("burst test done");
		xfer(8'h20, 1'b1, 16'h0005);
		xfer(8'h44, 1'b1, 16'h8000);
		oc_ref <= 3'h1;
		// locked dead time 0x55 holds the rising side back 85 cycles
		tick(40);
		chk(oc_out, 3'h0);
		chk(ocn_out, 3'h0);
		tick(60);
		chk(oc_out, 3'h1);
		chk(ocn_out, 3'h0);
		$display("dead-time test done");
		end_of_test;
	end
	initial begin
		#200000;
		bad_count++;
		end_of_test;
	end
endmodule
`default_nettype wire

// ---- verif/break_source.sv ----
// Purpose: far-side break sources, break pin and clock-failure event
// Assumes: bench commands arrive just after a rising edge
// Notes: the pin idles at the inverse of its active level, never floats
`default_nettype none
module break_source (
	input wire logic pclk,
	input wire logic pol,
	input wire logic trip_pin,
	input wire logic trip_cf,
	output logic break_pin,
	output logic clock_fail_detect
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		break_pin = 1'b1;
		clock_fail_detect = 1'b0;
	end
	always @(posedge pclk) begin
		break_pin <= trip_pin ? pol : ~pol;
		clock_fail_detect <= trip_cf;
	end
endmodule
`default_nettype wire
